// [hdl/dram_and_page_rom_control.sv]
// DRAM and page-ROM access controller with CBR and self refresh
//
// Overview of operation
// - DRAM on-page takes 2 or 3 clocks, off-page 4 or 5 clocks
// - Row address then column address go out on same pins
// - Multiplex width 8, 9, 10 or 11 bits from split field
// - Width 11 puts a12-a22 as row and a1-a11 as column on A1-A11
// - Distributed CBR refresh, enable and interval from refresh control
// - Refresh due while bus held: drop hold grant, do not seize bus
// - Self-refresh on HALT when standby select is IDLE or STOP
// - Self-refresh row strobe held at least 100 us
// - Self-refresh ends on reset or nonmaskable interrupt
// - Page-ROM cycles only for address block 3
// - Latch page-ROM address and compare with next one
// - Bits A3-A5 excluded from comparison per page-ROM config
// - Page width 8 to 64 bytes set by the mask
// - Separate wait counts for on-page and off-page ROM access
// - DRAM cycles only in address block 0
`timescale 1ns/10ps
`default_nettype none
`include "memctl_defines.svh"
module dram_and_page_rom_control
   import memctl_pkg::*;
#(
   parameter int SELF_RAS_CYCLES = `SELF_RAS_CYC
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic accReq,
   input wire logic [`ADDR_W-1:0] accAddr,
   input wire logic dramExtraWait,
   input wire logic [1:0] rowColSplitWidth,
   input wire logic refreshEnable,
   input wire logic [`RFI_W-1:0] refreshInterval,
   input wire logic [1:0] standbySelect,
   input wire logic haltExec,
   input wire logic nmiIn,
   input wire logic holdRequestIn,
   input wire logic [2:0] pageRomMask,
   input wire logic [`WAIT_W-1:0] promOffWait,
   input wire logic promOnWait,
   output logic accDone,
   output logic accOnPage,
   output logic [`ADDR_W-1:0] addrOut,
   output logic rowStrobeN,
   output logic lowerColumnStrobeN,
   output logic upperColumnStrobeN,
   output logic refreshRequestOutN,
   output logic holdGrant,
   output logic selfRefreshActive
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      memState_t st;
      logic [15:0] cnt;
      logic [`RFI_W-1:0] rfTimer;
      logic [3:0] rfPending;
      logic [`ADDR_W-1:0] rowOpen;
      logic rowValid;
      logic [`ADDR_W-1:0] promLast;
      logic promValid;
      logic [`ADDR_W-1:0] addr;
      logic ras;
      logic cas;
      logic done;
      logic onPg;
      logic grant;
      logic selfRf;
      logic [2:0] holdSync;
      logic [2:0] nmiSync;
      logic holdLvl;
      logic nmiLvl;
      logic rfReq;
   } ctlState_t;

   ctlState_t s_q, s_d;
   logic promHit;
   logic holdReqS, nmiS;

   // A change counts only once the last two sync stages agree
   assign holdReqS = (s_q.holdSync[2] == s_q.holdSync[1]) ?
      s_q.holdSync[1] : s_q.holdLvl;
   assign nmiS = (s_q.nmiSync[2] == s_q.nmiSync[1]) ?
      s_q.nmiSync[1] : s_q.nmiLvl;

   page_compare u_cmp (
      .curAddr(accAddr),
      .lastAddr(s_q.promLast),
      .lastValid(s_q.promValid),
      .pageMask(pageRomMask),
      .onPage(promHit)
   );

   // Row part of the address, shifted down by the split width
   function automatic logic [`ADDR_W-1:0] rowAddr(
      input logic [`ADDR_W-1:0] a, input logic [1:0] w);
      logic [`ADDR_W-1:0] r;
      r = a;
      unique case (w)
         `SPLIT_8: r[8:1] = a[16:9];
         `SPLIT_9: r[9:1] = a[18:10];
         `SPLIT_10: r[10:1] = a[20:11];
         `SPLIT_11: r[11:1] = a[22:12];
      endcase
      return r;
   endfunction

   // Mask of column bits for the split width, used for page hit
   function automatic logic [`ADDR_W-1:0] colMask(input logic [1:0] w);
      logic [`ADDR_W-1:0] m;
      m = '0;
      unique case (w)
         `SPLIT_8: m[8:0] = 9'h1FF;
         `SPLIT_9: m[9:0] = 10'h3FF;
         `SPLIT_10: m[10:0] = 11'h7FF;
         `SPLIT_11: m[11:0] = 12'hFFF;
      endcase
      return m;
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [1:0] blk;
      logic dramSameRow;
      logic take;
      s_d = s_q;
      blk = accAddr[`BLOCK_HI:`BLOCK_LO];
      // Request still high in the done cycle belongs to the finished access
      take = accReq && !s_q.done;
      dramSameRow = s_q.rowValid &&
         ((accAddr & ~colMask(rowColSplitWidth)) ==
          (s_q.rowOpen & ~colMask(rowColSplitWidth)));
      s_d.holdSync = {s_q.holdSync[1:0], holdRequestIn};
      s_d.nmiSync = {s_q.nmiSync[1:0], nmiIn};
      s_d.holdLvl = holdReqS;
      s_d.nmiLvl = nmiS;
      s_d.done = 1'b0;
      // Interval timer keeps running so up to 15 due refreshes stay pending
      if (refreshEnable) begin
         if (s_q.rfTimer == '0) begin
            s_d.rfTimer = refreshInterval;
            if (s_q.rfPending != `RFP_MAX)
               s_d.rfPending = s_q.rfPending + 4'h1;
         end else begin
            s_d.rfTimer = s_q.rfTimer - 1'b1;
         end
      end else begin
         s_d.rfTimer = refreshInterval;
      end
      // Grant drops while a refresh is pending to ask for the bus back
      s_d.grant = holdReqS && (s_q.rfPending == '0) &&
         (s_q.st == ST_IDLE);
      unique case (s_q.st)
         ST_IDLE: begin
            s_d.cnt = '0;
            if (s_q.grant || holdReqS) begin
               // Bus belongs to the other master; refresh waits
               s_d.ras = 1'b0;
               s_d.cas = 1'b0;
               s_d.rowValid = 1'b0;
            end else if (haltExec && (standbySelect == `STBY_IDLE ||
                        standbySelect == `STBY_STOP)) begin
               s_d.st = ST_RFCAS;
               s_d.selfRf = 1'b1;
               s_d.cas = 1'b1;
               s_d.ras = 1'b0;
               s_d.rowValid = 1'b0;
            end else if (s_q.rfPending != '0) begin
               s_d.st = ST_RFCAS;
               s_d.rfPending = s_d.rfPending - 4'h1;
               s_d.cas = 1'b1;
               s_d.ras = 1'b0;
               s_d.rowValid = 1'b0;
            end else if (take && blk == `BLOCK_DRAM) begin
               s_d.addr = rowAddr(accAddr, rowColSplitWidth);
               s_d.rowOpen = accAddr;
               s_d.rowValid = 1'b1;
               s_d.onPg = dramSameRow;
               if (dramSameRow) begin
                  // RAS stays low through fast page mode
                  s_d.st = ST_COL;
                  s_d.addr = accAddr;
                  s_d.cas = 1'b1;
                  s_d.cnt = {15'h0, dramExtraWait};
               end else begin
                  s_d.st = ST_ROW;
                  s_d.ras = 1'b0;
                  s_d.cas = 1'b0;
                  s_d.cnt = {15'h0, dramExtraWait} + 16'h1;
               end
            end else if (take && blk == `BLOCK_PROM) begin
               s_d.st = ST_PROM;
               s_d.addr = accAddr;
               s_d.onPg = promHit;
               s_d.promLast = accAddr;
               s_d.promValid = 1'b1;
               s_d.cnt = promHit ? {15'h0, promOnWait} :
                  {13'h0, promOffWait};
            end
         end
         ST_ROW: begin
            // First clock row strobe falls; column after the wait
            s_d.ras = 1'b1;
            if (s_q.cnt == '0) begin
               s_d.st = ST_COL;
               s_d.addr = accAddr;
               s_d.cas = 1'b1;
            end else begin
               s_d.cnt = s_q.cnt - 16'h1;
            end
         end
         ST_COL: begin
            if (s_q.cnt == '0) begin
               s_d.cas = 1'b0;
               s_d.done = 1'b1;
               s_d.st = ST_IDLE;
            end else begin
               s_d.cnt = s_q.cnt - 16'h1;
            end
         end
         ST_PROM: begin
            if (s_q.cnt == '0) begin
               s_d.done = 1'b1;
               s_d.st = ST_IDLE;
            end else begin
               s_d.cnt = s_q.cnt - 16'h1;
            end
         end
         ST_RFCAS: begin
            s_d.ras = 1'b1;
            s_d.st = s_q.selfRf ? ST_SELF : ST_RFRAS;
            s_d.cnt = s_q.selfRf ? 16'(SELF_RAS_CYCLES) : 16'(`CBR_WAIT);
         end
         ST_RFRAS: begin
            if (s_q.cnt == '0) begin
               s_d.st = ST_DONE;
               s_d.ras = 1'b0;
               s_d.cas = 1'b0;
            end else begin
               s_d.cnt = s_q.cnt - 16'h1;
            end
         end
         ST_SELF: begin
            if (s_q.cnt != '0)
               s_d.cnt = s_q.cnt - 16'h1;
            // Exit only after minimum pulse; NMI held by caller
            if (s_q.cnt == '0 && nmiS) begin
               s_d.st = ST_DONE;
               s_d.ras = 1'b0;
               s_d.cas = 1'b0;
               s_d.selfRf = 1'b0;
            end
         end
         ST_DONE: s_d.st = ST_IDLE;
      endcase
      s_d.rfReq = (s_d.rfPending != '0);
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_q <= '{st: ST_IDLE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign accDone = s_q.done;
   assign accOnPage = s_q.onPg;
   assign addrOut = s_q.addr;
   assign rowStrobeN = ~s_q.ras;
   assign lowerColumnStrobeN = ~s_q.cas;
   assign upperColumnStrobeN = ~s_q.cas;
   assign refreshRequestOutN = ~s_q.rfReq;
   assign holdGrant = s_q.grant;
   assign selfRefreshActive = s_q.selfRf;
endmodule
`default_nettype wire

// [hdl/memctl_defines.svh]
// Constants for the DRAM and page-ROM access controller
`ifndef MEMCTL_DEFINES_SVH
`define MEMCTL_DEFINES_SVH
`define ADDR_W 24
`define BLOCK_HI 23
`define BLOCK_LO 22
`define BLOCK_DRAM 2'h0
`define BLOCK_PROM 2'h3
`define SPLIT_8 2'h0
`define SPLIT_9 2'h1
`define SPLIT_10 2'h2
`define SPLIT_11 2'h3
`define STBY_HALT 2'h0
`define STBY_IDLE 2'h1
`define STBY_STOP 2'h2
`define SELF_RAS_US 100
`define CLK_MHZ 50
`define SELF_RAS_CYC (`SELF_RAS_US * `CLK_MHZ)
`define RFI_W 8
`define WAIT_W 3
`define PMASK_LO 3
`define PMASK_HI 5
`define CBR_WAIT 2
`define RFP_MAX 4'hF
`endif

// [hdl/memctl_pkg.sv]
// Types for the DRAM and page-ROM access controller
package memctl_pkg;
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_ROW = 8'h02,
      ST_COL = 8'h04,
      ST_PROM = 8'h08,
      ST_RFCAS = 8'h10,
      ST_RFRAS = 8'h20,
      ST_SELF = 8'h40,
      ST_DONE = 8'h80
   } memState_t;
endpackage

// [hdl/page_compare.sv]
// Page-ROM on-page/off-page decision with masked address comparison
`timescale 1ns/10ps
`default_nettype none
`include "memctl_defines.svh"
module page_compare
   import memctl_pkg::*;
(
   input wire logic [`ADDR_W-1:0] curAddr,
   input wire logic [`ADDR_W-1:0] lastAddr,
   input wire logic lastValid,
   input wire logic [2:0] pageMask,
   output logic onPage
);
   logic [`ADDR_W-1:0] cmpMask;
   always_comb begin
      // Bits below A3 are always within a page (8-byte minimum)
      cmpMask = '1;
      cmpMask[`PMASK_LO-1:0] = 3'h0;
      cmpMask[`PMASK_HI:`PMASK_LO] = ~pageMask;
      onPage = lastValid &&
         ((curAddr & cmpMask) == (lastAddr & cmpMask));
   end
endmodule
`default_nettype wire

// [verif/hold_master.sv]
// Outside bus master that borrows the bus through the hold handshake
`timescale 1ns/10ps
`default_nettype none
module hold_master (
   input wire logic clk_sys,
   input wire logic want,
   input wire logic holdGrant,
   output logic holdRequestIn
);
   logic granted;
   // Stays off the bus after a withdrawn grant so the refresh can run
   always @(posedge clk_sys) begin
      if (!want) begin
         holdRequestIn <= 1'b0;
         granted <= 1'b0;
      end else begin
         if (holdGrant) granted <= 1'b1;
         if (granted && !holdGrant) begin
            holdRequestIn <= 1'b0;
         end else if (!granted) begin
            holdRequestIn <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// [verif/memctl_asserts.sv]
// Concurrent checks on the memory access controller ports
`timescale 1ns/10ps
`default_nettype none
`include "memctl_defines.svh"
module memctl_asserts
   import memctl_pkg::*;
#(
   parameter int SELF_RAS_CYCLES = `SELF_RAS_CYC
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic accReq,
   input wire logic [`ADDR_W-1:0] accAddr,
   input wire logic dramExtraWait,
   input wire logic [1:0] rowColSplitWidth,
   input wire logic refreshEnable,
   input wire logic [`RFI_W-1:0] refreshInterval,
   input wire logic [1:0] standbySelect,
   input wire logic haltExec,
   input wire logic nmiIn,
   input wire logic holdRequestIn,
   input wire logic [2:0] pageRomMask,
   input wire logic [`WAIT_W-1:0] promOffWait,
   input wire logic promOnWait,
   input wire logic accDone,
   input wire logic accOnPage,
   input wire logic [`ADDR_W-1:0] addrOut,
   input wire logic rowStrobeN,
   input wire logic lowerColumnStrobeN,
   input wire logic upperColumnStrobeN,
   input wire logic refreshRequestOutN,
   input wire logic holdGrant,
   input wire logic selfRefreshActive
);
   int lowCnt;
   // Row strobe low time, for the self-refresh width
   always_ff @(posedge clk_sys) begin
      lowCnt <= rowStrobeN ? 0 : lowCnt + 1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   sequence rowOpen;
      $fell(rowStrobeN) && lowerColumnStrobeN;
   endsequence
   sequence cbrStart;
      $fell(lowerColumnStrobeN) && rowStrobeN;
   endsequence
   AST_RESET_IDLE: assert property (disable iff (1'b0)
      reset |=> rowStrobeN && lowerColumnStrobeN && !holdGrant && !accDone)
      else $error("outputs not idle after reset");
   AST_DONE_PULSE: assert property (accDone |=> !accDone)
      else $error("done longer than one cycle");
   AST_ROW_COL: assert property (rowOpen |->
      ##[1:2] (!lowerColumnStrobeN && !rowStrobeN))
      else $error("column strobe late after row");
   AST_CBR: assert property (cbrStart |=> !rowStrobeN)
      else $error("refresh row strobe not after column");
   AST_BLOCK: assert property (accDone |->
      accAddr[23:22] inside {`BLOCK_DRAM, `BLOCK_PROM})
      else $error("cycle ran in a foreign block");
   AST_NO_SEIZE: assert property (holdGrant |->
      rowStrobeN && lowerColumnStrobeN)
      else $error("bus used while granted away");
   AST_GRANT_DROP: assert property ($fell(refreshRequestOutN)
      && holdGrant |-> ##[0:3] !holdGrant)
      else $error("grant kept with refresh pending");
   AST_SELF_IN: assert property ($rose(selfRefreshActive) |->
      $past(standbySelect) inside {`STBY_IDLE, `STBY_STOP})
      else $error("self refresh in wrong mode");
   AST_SELF_RAS: assert property ($rose(rowStrobeN)
      && $past(selfRefreshActive) |-> lowCnt >= SELF_RAS_CYCLES)
      else $error("self refresh row strobe too short");
endmodule
bind dram_and_page_rom_control memctl_asserts
   #(.SELF_RAS_CYCLES(SELF_RAS_CYCLES)) chkInst (
   .clk_sys(clk_sys), .reset(reset), .accReq(accReq), .accAddr(accAddr),
   .dramExtraWait(dramExtraWait), .rowColSplitWidth(rowColSplitWidth),
   .refreshEnable(refreshEnable), .refreshInterval(refreshInterval),
   .standbySelect(standbySelect), .haltExec(haltExec), .nmiIn(nmiIn),
   .holdRequestIn(holdRequestIn), .pageRomMask(pageRomMask),
   .promOffWait(promOffWait), .promOnWait(promOnWait), .accDone(accDone),
   .accOnPage(accOnPage), .addrOut(addrOut), .rowStrobeN(rowStrobeN),
   .lowerColumnStrobeN(lowerColumnStrobeN),
   .upperColumnStrobeN(upperColumnStrobeN),
   .refreshRequestOutN(refreshRequestOutN), .holdGrant(holdGrant),
   .selfRefreshActive(selfRefreshActive)
);
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the memory access controller
`timescale 1ns/10ps
`default_nettype none
module tb
   import memctl_pkg::*;
;
   logic clk_sys, reset, accReq, dramExtraWait, refreshEnable, haltExec;
   logic nmiIn, promOnWait, holdWant, holdRequestIn, accDone, accOnPage;
   logic rowStrobeN, lowerColumnStrobeN, upperColumnStrobeN, holdGrant;
   logic refreshRequestOutN, selfRefreshActive;
   logic [23:0] accAddr, addrOut, rowSeen;
   logic [1:0] rowColSplitWidth, standbySelect;
   logic [7:0] refreshInterval;
   logic [2:0] pageRomMask, promOffWait;
   int nErrors = 0, cmpCount = 0, cyc = 0;
   dram_and_page_rom_control #(.SELF_RAS_CYCLES(20)) dut (
      .clk_sys, .reset, .accReq, .accAddr, .dramExtraWait,
      .rowColSplitWidth, .refreshEnable, .refreshInterval,
      .standbySelect, .haltExec, .nmiIn, .holdRequestIn, .pageRomMask,
      .promOffWait, .promOnWait, .accDone, .accOnPage, .addrOut,
      .rowStrobeN, .lowerColumnStrobeN, .upperColumnStrobeN,
      .refreshRequestOutN, .holdGrant, .selfRefreshActive
   );
   hold_master hm (.clk_sys, .want(holdWant), .holdGrant, .holdRequestIn);
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic wrap_up;
      $display("Compares %0d, mismatches %0d", cmpCount, nErrors);
      if (nErrors == 0 && cmpCount > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         nErrors++;
         wrap_up();
      end
   end
   task automatic chk(input logic [23:0] s, input logic [23:0] e);
      cmpCount++;
      if (s !== e) begin
         nErrors++;
         $display("MISMATCH %0t seen %h want %h", $time, s, e);
      end
   endtask
   task automatic acc(input logic [23:0] a, output int n);
      @(posedge clk_sys);
      accAddr <= a;
      accReq <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
         if (!rowStrobeN && lowerColumnStrobeN && !accDone)
            rowSeen = addrOut;
      end while (accDone !== 1'b1 && n < 60);
      accReq <= 1'b0;
      chk(accDone, 1'b1);
      chk(upperColumnStrobeN, 1'b1);
   endtask
   //----------------------------------------------------------------
   // Main sequence
   //----------------------------------------------------------------
   initial begin
      int n1, n2;
      logic [23:0] a, b, m;
      {reset, accReq, dramExtraWait, refreshEnable, haltExec} = 5'h10;
      {nmiIn, promOnWait, holdWant, accAddr} = 27'h0;
      {rowColSplitWidth, standbySelect, pageRomMask, promOffWait} = 10'h0;
      refreshInterval = 8'h0F;
      n1 = $urandom(32'hA1F8);
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      for (int w = 0; w < 4; w++) begin
         rowColSplitWidth <= w[1:0];
         dramExtraWait <= 1'($urandom);
         m = (24'h1 << (9 + w)) - 24'h2;
         a = {2'h0, 22'($urandom)};
         acc(a, n1);
         chk(addrOut & m, a & m);
         if (w == 3) chk(rowSeen[11:1], a[22:12]);
         acc((a & ~m) | (24'($urandom) & m), n2);
         chk(accOnPage, 1'b1);
         chk(n1 - n2, 24'h2);
      end
      promOffWait <= 3'($urandom);
      promOnWait <= 1'($urandom);
      pageRomMask <= 3'h7;
      a = {2'h3, 22'($urandom)};
      acc(a, n1);
      acc(a ^ 24'h38, n2);
      chk(accOnPage, 1'b1);
      chk(n1 - n2, promOffWait - promOnWait);
      acc(a ^ 24'h78, n1);
      chk(accOnPage, 1'b0);
      pageRomMask <= 3'h1;
      acc(a ^ 24'h70, n1);
      chk(accOnPage, 1'b1);
      acc(a ^ 24'h60, n1);
      chk(accOnPage, 1'b0);
      @(posedge clk_sys);
      accAddr <= 24'h400000;
      accReq <= 1'b1;
      b = 24'h0;
      repeat (20) begin
         @(posedge clk_sys);
         b |= accDone;
      end
      accReq <= 1'b0;
      chk(b, 24'h0);
      holdWant <= 1'b1;
      for (n1 = 0; n1 < 50 && holdGrant !== 1'b1; n1++) @(posedge clk_sys);
      chk(holdGrant, 1'b1);
      refreshEnable <= 1'b1;
      for (n1 = 0; n1 < 99 && holdGrant !== 1'b0; n1++) @(posedge clk_sys);
      chk(holdGrant, 1'b0);
      chk(refreshRequestOutN, 1'b0);
      for (n1 = 0; n1 < 99 && lowerColumnStrobeN !== 1'b0; n1++)
         @(posedge clk_sys);
      chk(rowStrobeN, 1'b1);
      chk(upperColumnStrobeN, 1'b0);
      n2 = 0;
      repeat (320) begin
         @(posedge clk_sys);
         n2 += (!lowerColumnStrobeN && rowStrobeN) ? 1 : 0;
      end
      chk(n2 inside {[19:22]}, 1'b1);
      refreshEnable <= 1'b0;
      holdWant <= 1'b0;
      for (int s = 0; s < 3; s++) begin
         standbySelect <= s[1:0];
         haltExec <= 1'b1;
         repeat (40) @(posedge clk_sys);
         chk(selfRefreshActive, s != 0);
         nmiIn <= s == 1;
         reset <= s == 2;
         haltExec <= 1'b0;
         repeat (2) @(posedge clk_sys);
         reset <= 1'b0;
         nmiIn <= 1'b0;
         for (n1 = 0; n1 < 60 && selfRefreshActive !== 1'b0; n1++)
            @(posedge clk_sys);
         chk(selfRefreshActive, 1'b0);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
